// *** core/nvm_pkg.sv ***
// Package with constants and types shared by the flash data memory ends
package nvm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int LOC_W = 6;
    localparam int DEPTH = 64;
    localparam int ROW_LSB = 3;
    localparam int ROW_MSB = 5;
    localparam int ROW_LEN = 8;
    // Special function register selectors on the core port
    localparam logic [1:0] SFR_POINTER = 2'h0;
    localparam logic [1:0] SFR_BUFFER = 2'h1;
    localparam logic [1:0] SFR_CONTROL = 2'h2;
    // Control register bit positions
    localparam int BIT_READ = 0;
    localparam int BIT_PROG = 1;
    localparam int BIT_UNLOCK = 2;
    localparam int BIT_ERASE = 3;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
    // Array cycle times in instruction cycles
    localparam logic [7:0] READ_CYCLES = 8'h01;
    localparam logic [7:0] ERASE_CYCLES = 8'h10;
    localparam logic [7:0] WRITE_CYCLES = 8'h08;
    // APB register offsets of the controller
    localparam logic [11:0] OFS_CMD = 12'h000;
    localparam logic [11:0] OFS_ADDR = 12'h004;
    localparam logic [11:0] OFS_WDATA = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam logic [11:0] OFS_RDATA = 12'h010;
    // Controller commands
    localparam logic [1:0] CMD_READ = 2'h1;
    localparam logic [1:0] CMD_ERASE = 2'h2;
    localparam logic [1:0] CMD_WRITE = 2'h3;
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_READ = 2'b01,
        OP_ERASE = 2'b10,
        OP_WRITE = 2'b11
    } op_t;
    typedef enum logic [3:0] {
        C_IDLE = 4'b0000,
        C_PTR = 4'b0001,
        C_BUF = 4'b0010,
        C_RD = 4'b0011,
        C_FREE = 4'b0100,
        C_UNLK = 4'b0101,
        C_PROG = 4'b0110,
        C_WAIT = 4'b0111,
        C_FETCH = 4'b1000,
        C_DONE = 4'b1001
    } ctl_state_t;
endpackage

// *** core/nvm_if.sv ***
// Interface joining the core-side sequencer to the flash data memory block
`timescale 1ns/1ps
interface nvm_if;
    import nvm_pkg::*;
    logic wr_en;
    logic bitset;
    logic [1:0] sel;
    logic [DATA_W-1:0] wdata;
    logic [2:0] bit_no;
    logic [DATA_W-1:0] rdata_pointer;
    logic [DATA_W-1:0] rdata_buffer;
    logic [DATA_W-1:0] rdata_control;
    logic stall;
    modport device (input wr_en, bitset, sel, wdata, bit_no,
                    output rdata_pointer, rdata_buffer, rdata_control, stall);
    modport core (output wr_en, bitset, sel, wdata, bit_no,
                  input rdata_pointer, rdata_buffer, rdata_control, stall);
endinterface

// *** core/nvm_device.sv ***
// Flash data memory block with pointer, buffer and control registers
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - Array reached only through three registers
// - Read trigger loads buffer from pointer location
// - Buffer holds until next read or write
// - Stall core while read runs
// - Read starts only on single bit set
// - 64 bytes, eight rows, row erase, byte write
// - Core erases row before writing byte; the sequencer's write command issues no erase first
// - Erase: pointer, erase select, unlock, trigger
// - Erase select cleared without unlock next cycle
// - Unlock cleared without trigger next cycle
// - Unlock and trigger only by bit set
// - Pointer bits 5:3 choose erased row
// - Stall core while erase runs
// - Write: pointer, buffer, unlock, trigger
// - Stall during write, program buffered byte
// - Next instruction executes without filler
// - Code protection never blocks these accesses
module nvm_device (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Core side
    nvm_if.device bus
);
    import nvm_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] pointer;
        logic [DATA_W-1:0] buffer;
        logic read_go;
        logic prog_go;
        logic unlock;
        logic erase_sel;
        logic unlock_age;
        logic erase_age;
        op_t op;
        logic [7:0] count;
        logic stall;
    } dev_state_t;

    localparam int ROW_W = ROW_MSB - ROW_LSB + 1;
    localparam int ROWS = DEPTH / ROW_LEN;

    dev_state_t s;
    dev_state_t next_s;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] control_view;

    logic [LOC_W-1:0] loc;
    logic [ROW_W-1:0] row;
    logic idle;
    logic is_ctl_wr;
    logic set_one;
    logic ptr_wr;
    logic buf_wr;
    logic full_ctl_wr;
    logic set_unlock;
    logic set_prog;
    logic erase_miss;
    logic unlock_miss;
    logic last_cycle;
    logic mem_write;
    logic mem_erase;
    logic [ROWS-1:0] row_erase;
    logic [DEPTH-1:0] byte_write;

    assign loc = s.pointer[LOC_W-1:0];
    assign row = loc[ROW_MSB:ROW_LSB];
    assign idle = s.op == OP_IDLE;

    // Register writes land only while idle; the stall holds the core otherwise
    assign is_ctl_wr = idle && bus.wr_en && bus.sel == SFR_CONTROL;
    assign set_one = is_ctl_wr && bus.bitset;
    assign ptr_wr = idle && bus.wr_en && bus.sel == SFR_POINTER;
    assign buf_wr = idle && bus.wr_en && bus.sel == SFR_BUFFER;
    assign full_ctl_wr = is_ctl_wr && !bus.bitset;
    assign set_unlock = set_one && bus.bit_no == 3'(BIT_UNLOCK);
    assign set_prog = set_one && bus.bit_no == 3'(BIT_PROG);

    // An armed step that the very next instruction does not follow is dropped
    assign erase_miss = s.erase_sel && s.erase_age && !set_unlock;
    assign unlock_miss = s.unlock && s.unlock_age && !set_prog;

    // Code protection has no input here, so accesses are never blocked
    assign last_cycle = !idle && s.count == READ_CYCLES;
    assign mem_write = s.op == OP_WRITE && last_cycle;
    assign mem_erase = s.op == OP_ERASE && last_cycle;

    // One erase strobe per row and one program strobe per byte
    for (genvar r = 0; r < ROWS; r++) begin : g_row
        assign row_erase[r] = mem_erase && row == ROW_W'(r);
    end
    for (genvar b = 0; b < DEPTH; b++) begin : g_byte
        assign byte_write[b] = mem_write && loc == LOC_W'(b);
    end

    // Control read-back; bits above the erase select read as zero
    assign control_view[DATA_W-1:BIT_ERASE+1] = '0;
    assign control_view[BIT_ERASE] = s.erase_sel;
    assign control_view[BIT_UNLOCK] = s.unlock;
    assign control_view[BIT_PROG] = s.prog_go;
    assign control_view[BIT_READ] = s.read_go;

    always_comb begin
        next_s = s;
        // Each chain step stays armed for one instruction cycle only
        next_s.erase_age = 1'b0;
        next_s.unlock_age = 1'b0;
        if (idle) begin
            if (ptr_wr) begin
                next_s.pointer = bus.wdata;
            end
            if (buf_wr) begin
                next_s.buffer = bus.wdata;
            end
            if (erase_miss) begin
                next_s.erase_sel = 1'b0;
            end
            if (unlock_miss) begin
                next_s.unlock = 1'b0;
            end
            if (full_ctl_wr) begin
                next_s.erase_sel = bus.wdata[BIT_ERASE];
                next_s.erase_age = bus.wdata[BIT_ERASE];
            end
            if (set_one) begin
                case (bus.bit_no)
                    3'(BIT_ERASE): begin
                        next_s.erase_sel = 1'b1;
                        next_s.erase_age = 1'b1;
                    end
                    3'(BIT_UNLOCK): begin
                        next_s.unlock = 1'b1;
                        next_s.unlock_age = 1'b1;
                    end
                    3'(BIT_READ): begin
                        next_s.read_go = 1'b1;
                        next_s.op = OP_READ;
                        next_s.count = READ_CYCLES;
                        next_s.stall = 1'b1;
                    end
                    3'(BIT_PROG): begin
                        if (s.unlock && s.unlock_age) begin
                            next_s.prog_go = 1'b1;
                            next_s.stall = 1'b1;
                            if (s.erase_sel) begin
                                next_s.op = OP_ERASE;
                                next_s.count = ERASE_CYCLES;
                            end else begin
                                next_s.op = OP_WRITE;
                                next_s.count = WRITE_CYCLES;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else begin
            next_s.count = s.count - 8'h01;
            if (s.op == OP_READ) begin
                next_s.buffer = mem[loc];
            end
            if (s.count == READ_CYCLES) begin
                // Finish; stall drops so the next instruction runs at once
                next_s.op = OP_IDLE;
                next_s.stall = 1'b0;
                next_s.read_go = 1'b0;
                next_s.prog_go = 1'b0;
                next_s.unlock = 1'b0;
                next_s.erase_sel = 1'b0;
                next_s.unlock_age = 1'b0;
                next_s.erase_age = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Array: row erase and byte write
    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (srst) begin
                mem[i] <= ERASED_BYTE;
            end else if (row_erase[i / ROW_LEN]) begin
                mem[i] <= ERASED_BYTE;
            end else if (byte_write[i]) begin
                mem[i] <= mem[i] & s.buffer;
            end
        end
    end

    assign bus.rdata_pointer = s.pointer;
    assign bus.rdata_buffer = s.buffer;
    assign bus.rdata_control = control_view;
    assign bus.stall = s.stall;
endmodule

// *** core/nvm_core_ctl.sv ***
// Core-side sequencer that issues register and bit-set steps from APB commands
`timescale 1ns/1ps
module nvm_core_ctl (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash data memory side
    nvm_if.core bus
);
    import nvm_pkg::*;

    typedef struct packed {
        ctl_state_t st;
        logic [1:0] cmd;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic busy;
        logic wr_en;
        logic bitset;
        logic [1:0] sel;
        logic [DATA_W-1:0] bwdata;
        logic [2:0] bit_no;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ctl_s_t;

    ctl_s_t s;
    ctl_s_t next_s;
    logic access;

    assign access = psel && penable && !s.pready;

    always_comb begin
        next_s = s;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.wr_en = 1'b0;
        next_s.bitset = 1'b0;
        if (access) begin
            next_s.pready = 1'b1;
            next_s.prdata = '0;
            case (paddr)
                OFS_CMD: begin
                    if (pwrite && !s.busy && pwdata[1:0] != 2'h0) begin
                        next_s.cmd = pwdata[1:0];
                        next_s.busy = 1'b1;
                        next_s.st = C_PTR;
                    end
                end
                OFS_ADDR: begin
                    if (pwrite) begin
                        next_s.addr = pwdata[DATA_W-1:0];
                    end
                    next_s.prdata = {24'h0, s.addr};
                end
                OFS_WDATA: begin
                    if (pwrite) begin
                        next_s.wdata = pwdata[DATA_W-1:0];
                    end
                    next_s.prdata = {24'h0, s.wdata};
                end
                OFS_STATUS: next_s.prdata = {31'h0, s.busy};
                OFS_RDATA: next_s.prdata = {24'h0, s.rdata};
                default: next_s.pslverr = 1'b1;
            endcase
        end
        // One step per cycle; the stall freezes the sequence
        if (!bus.stall) begin
            case (s.st)
                C_IDLE: begin
                end
                C_PTR: begin
                    next_s.wr_en = 1'b1;
                    next_s.sel = SFR_POINTER;
                    next_s.bwdata = s.addr;
                    case (s.cmd)
                        CMD_READ: next_s.st = C_RD;
                        CMD_ERASE: next_s.st = C_FREE;
                        default: next_s.st = C_BUF;
                    endcase
                end
                C_BUF: begin
                    next_s.wr_en = 1'b1;
                    next_s.sel = SFR_BUFFER;
                    next_s.bwdata = s.wdata;
                    next_s.st = C_UNLK;
                end
                C_RD: begin
                    next_s.wr_en = 1'b1;
                    next_s.bitset = 1'b1;
                    next_s.sel = SFR_CONTROL;
                    next_s.bit_no = 3'(BIT_READ);
                    next_s.st = C_WAIT;
                end
                C_FREE: begin
                    next_s.wr_en = 1'b1;
                    next_s.bitset = 1'b1;
                    next_s.sel = SFR_CONTROL;
                    next_s.bit_no = 3'(BIT_ERASE);
                    next_s.st = C_UNLK;
                end
                C_UNLK: begin
                    next_s.wr_en = 1'b1;
                    next_s.bitset = 1'b1;
                    next_s.sel = SFR_CONTROL;
                    next_s.bit_no = 3'(BIT_UNLOCK);
                    next_s.st = C_PROG;
                end
                C_PROG: begin
                    next_s.wr_en = 1'b1;
                    next_s.bitset = 1'b1;
                    next_s.sel = SFR_CONTROL;
                    next_s.bit_no = 3'(BIT_PROG);
                    next_s.st = C_WAIT;
                end
                C_WAIT: next_s.st = C_FETCH;
                C_FETCH: begin
                    next_s.rdata = bus.rdata_buffer;
                    next_s.st = C_DONE;
                end
                C_DONE: begin
                    next_s.busy = 1'b0;
                    next_s.st = C_IDLE;
                end
                default: next_s.st = C_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign bus.wr_en = s.wr_en;
    assign bus.bitset = s.bitset;
    assign bus.sel = s.sel;
    assign bus.wdata = s.bwdata;
    assign bus.bit_no = s.bit_no;
endmodule

// *** verif/nvm_link_properties.sv ***
// Checker of the link between the core-side sequencer and the flash data memory block
`timescale 1ns/1ps
module nvm_link_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Link signals
    input wire logic wr_en,
    input wire logic bitset,
    input wire logic [1:0] sel,
    input wire logic [7:0] wdata,
    input wire logic [2:0] bit_no,
    input wire logic [7:0] rdata_pointer,
    input wire logic [7:0] rdata_buffer,
    input wire logic [7:0] rdata_control,
    input wire logic stall
);
    import nvm_pkg::*;
    logic [7:0] run_len;
    logic [7:0] run_exp;
    wire logic ctl_set = wr_en && bitset && sel == SFR_CONTROL && !stall;
    wire logic rd_set = ctl_set && bit_no == 3'(BIT_READ);
    wire logic unl_set = ctl_set && bit_no == 3'(BIT_UNLOCK);
    wire logic prg_set = ctl_set && bit_no == 3'(BIT_PROG);
    // Stall length and the length the last trigger asked for
    always_ff @(posedge clk) begin
        run_len <= (srst || !stall) ? 8'h00 : run_len + 8'h01;
        if (srst) begin
            run_exp <= 8'h00;
        end else if (rd_set) begin
            run_exp <= READ_CYCLES;
        end else if (prg_set) begin
            run_exp <= rdata_control[BIT_ERASE] ? ERASE_CYCLES : WRITE_CYCLES;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    property p_read_stall;
        rd_set |-> ##[1:2] stall;
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read trigger gave no stall");
    property p_op_len;
        $fell(stall) |-> run_len == run_exp;
    endproperty
    a_op_len: assert property (p_op_len) else $error("stall length wrong");
    property p_quiet_in_stall;
        stall |-> !wr_en;
    endproperty
    a_quiet_in_stall: assert property (p_quiet_in_stall) else $error("core wrote during stall");
    property p_clear_done;
        $fell(stall) |-> ##[0:1] rdata_control[3:0] == 4'h0;
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("control bits left set");
    property p_buf_hold;
        !stall && !wr_en |=> $stable(rdata_buffer);
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("buffer changed by itself");
    property p_ptr_load;
        wr_en && !bitset && sel == SFR_POINTER && !stall |=> ((rdata_pointer ^ $past(wdata)) & 8'h3f) == 8'h00;
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
    property p_buf_load;
        wr_en && !bitset && sel == SFR_BUFFER && !stall |=> rdata_buffer == $past(wdata);
    endproperty
    a_buf_load: assert property (p_buf_load) else $error("buffer not loaded");
    property p_unlock_src;
        $rose(rdata_control[BIT_UNLOCK]) |-> $past(unl_set);
    endproperty
    a_unlock_src: assert property (p_unlock_src) else $error("unlock set without bit set");
    property p_read_src;
        $rose(rdata_control[BIT_READ]) |-> $past(rd_set);
    endproperty
    a_read_src: assert property (p_read_src) else $error("read set without bit set");
    property p_unlock_drop;
        $rose(rdata_control[BIT_UNLOCK]) |-> ##[1:2] (stall || !rdata_control[BIT_UNLOCK]);
    endproperty
    a_unlock_drop: assert property (p_unlock_drop) else $error("unlock neither used nor cleared");
    c_erase: cover property ($fell(stall) && run_exp == ERASE_CYCLES);
    c_write: cover property ($fell(stall) && run_exp == WRITE_CYCLES);
    c_read: cover property ($fell(stall) && run_exp == READ_CYCLES);
endmodule

// *** verif/test_flash_data_memory_control.sv ***
// Testbench of the flash data memory ends joined through their interface
`timescale 1ns/1ps
module test_flash_data_memory_control;
    import nvm_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] lfsr = 32'h3540;
    logic [31:0] r;
    logic [31:0] x;
    logic e;
    logic [7:0] mem [64];
    int failures = 0;
    int checks = 0;
    nvm_if lk ();
    nvm_if lk2 ();
    always #2.5 clk = ~clk;
    nvm_core_ctl i_nvm_core_ctl (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(lk));
    nvm_device i_nvm_device (.clk(clk), .srst(srst), .bus(lk));
    nvm_device i_nvm_device_2 (.clk(clk), .srst(srst), .bus(lk2));
    nvm_link_properties i_nvm_link_properties (.clk(clk), .srst(srst), .wr_en(lk.wr_en), .bitset(lk.bitset),
        .sel(lk.sel), .wdata(lk.wdata), .bit_no(lk.bit_no), .rdata_pointer(lk.rdata_pointer),
        .rdata_buffer(lk.rdata_buffer), .rdata_control(lk.rdata_control), .stall(lk.stall));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            finish_test();
        end
    endtask
    task automatic op(input logic [1:0] c, input logic [7:0] a, input logic [7:0] d, input logic twice);
        int n;
        n = 0;
        apb(1'b1, OFS_ADDR, {24'h0, a});
        apb(1'b1, OFS_WDATA, {24'h0, d});
        apb(1'b1, OFS_CMD, {30'h0, c});
        if (twice) begin
            apb(1'b1, OFS_CMD, {30'h0, CMD_WRITE});
        end
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 60);
        if (n >= 60) begin
            failures++;
            finish_test();
        end
        if (c == CMD_READ) begin
            apb(1'b0, OFS_RDATA, 32'h0);
            check("read data", {24'h0, mem[a[5:0]]}, r);
        end else if (c == CMD_ERASE) begin
            for (int i = 0; i < 8; i++) mem[{a[5:3], i[2:0]}] = ERASED_BYTE;
        end else begin
            mem[a[5:0]] = mem[a[5:0]] & d;
        end
    endtask
    task automatic link(input logic b, input logic [1:0] s, input logic [7:0] d, input int k);
        @(posedge clk);
        lk2.wr_en <= 1'b1;
        lk2.bitset <= b;
        lk2.sel <= s;
        lk2.wdata <= d;
        lk2.bit_no <= 3'(k);
    endtask
    task automatic rest(input int n);
        int k;
        k = 0;
        @(posedge clk);
        lk2.wr_en <= 1'b0;
        repeat (n) @(posedge clk);
        @(negedge clk);
        while (lk2.stall !== 1'b0 && k < 40) begin
            @(negedge clk);
            k++;
        end
        if (k >= 40) begin
            failures++;
            finish_test();
        end
    endtask
    initial begin
        lk2.wr_en = 1'b0;
        lk2.bitset = 1'b0;
        lk2.sel = 2'h0;
        lk2.wdata = 8'h00;
        lk2.bit_no = 3'h0;
        for (int i = 0; i < 64; i++) mem[i] = ERASED_BYTE;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        op(CMD_READ, 8'hff, 8'h00, 1'b0);
        op(CMD_WRITE, 8'h3f, 8'h81, 1'b0);
        op(CMD_ERASE, 8'hc7, 8'h00, 1'b1);
        op(CMD_READ, 8'h3f, 8'h00, 1'b0);
        op(CMD_ERASE, 8'h38, 8'h00, 1'b0);
        op(CMD_READ, 8'h3f, 8'h00, 1'b0);
        op(CMD_WRITE, 8'h3e, 8'h42, 1'b0);
        op(CMD_READ, 8'h3e, 8'h00, 1'b0);
        $display("test corners done");
        repeat (80) begin
            x = rnd();
            op(x[1:0] == 2'h0 ? CMD_READ : x[1:0], x[15:8], x[23:16], x[24] && x[1:0] == CMD_ERASE);
        end
        for (int i = 0; i < 64; i++) op(CMD_READ, {x[7:6], i[5:0]}, 8'h00, 1'b0);
        $display("test random done");
        apb(1'b0, OFS_ADDR, 32'h0);
        check("address readback", {24'h0, x[7:6], 6'h3f}, r);
        apb(1'b0, OFS_WDATA, 32'h0);
        check("data readback", 32'h0, r);
        apb(1'b0, 12'h014, 32'h0);
        check("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, OFS_CMD, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("status idle", 32'h0, r);
        // Faulty core sequences and one direct byte write on the second link
        link(1'b0, SFR_POINTER, 8'hc0, 0);
        link(1'b0, SFR_BUFFER, 8'h00, 0);
        link(1'b0, SFR_CONTROL, 8'h07, 0);
        rest(2);
        check("pointer loaded", 32'hc0, {24'h0, lk2.rdata_pointer});
        check("buffer after full write", 32'h0, {24'h0, lk2.rdata_buffer});
        check("control after full write", 32'h0, {24'h0, lk2.rdata_control});
        link(1'b1, SFR_CONTROL, 8'(rnd()), BIT_ERASE);
        rest(2);
        check("erase select dropped", 32'h0, {24'h0, lk2.rdata_control});
        link(1'b1, SFR_CONTROL, 8'(rnd()), BIT_UNLOCK);
        rest(1);
        check("unlock dropped", 32'h0, {24'h0, lk2.rdata_control});
        link(1'b1, SFR_CONTROL, 8'(rnd()), BIT_PROG);
        rest(2);
        link(1'b1, SFR_CONTROL, 8'(rnd()), BIT_READ);
        rest(2);
        check("late trigger refused", {24'h0, ERASED_BYTE}, {24'h0, lk2.rdata_buffer});
        link(1'b0, SFR_BUFFER, 8'h5a, 0);
        link(1'b1, SFR_CONTROL, 8'(rnd()), BIT_UNLOCK);
        link(1'b1, SFR_CONTROL, 8'(rnd()), BIT_PROG);
        rest(2);
        link(1'b1, SFR_CONTROL, 8'(rnd()), BIT_READ);
        rest(2);
        check("direct byte write", 32'h5a, {24'h0, lk2.rdata_buffer});
        $display("test link faults done");
        finish_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule
